// File: pkg/dpctl_pkg.sv
/*
  Constants and carrier types for the datapath control word register block.
  Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
// Functional notes
// - Bit 15 enables offset correction for channel pair one; resets to zero.
// - Bit 14 enables offset correction for channel pair two; resets to zero.
// - Bit 13 enables gain and phase correction for pair one; clear bypasses it.
// - Bit 12 enables gain and phase correction for pair two; clear bypasses it.
// - Bits 11:8 select interpolation 1x as code zero, 2x,4x,8x,16x one-hot; reset is 8x.
// - Bit 7 enables the input FIFO; resets to one.
// - Bit 4 set drives the alarm pin; clear leaves it high impedance.
// - Bit 3 gives alarm polarity: zero active low, one active high.
// - Bit 2 lets the chosen sync source align the clock divider pointer.
// - After a sync event the divided clocks are phase aligned.
// - Bit 1 enables inverse-sinc filter of pair one; resets to zero.
// - Bit 0 enables inverse-sinc filter of pair two; resets to zero.
// - Bits 6 and 5 are reserved, reset zero, and have no effect.
// - The register sits at offset 0x00 and resets to 0x049C.
package dpctl_pkg;
  localparam logic [7:0] DATAPATH_CONTROL_0_OFS = 8'h00;
  localparam logic [7:0] CTRL_STATUS_OFS = 8'h04;
  localparam logic [15:0] DATAPATH_CONTROL_0_RST = 16'h049C;
  localparam logic [15:0] RESERVED_MASK = 16'h0060;
  localparam int BIT_OFFSET_P1 = 15;
  localparam int BIT_OFFSET_P2 = 14;
  localparam int BIT_GP_P1 = 13;
  localparam int BIT_GP_P2 = 12;
  localparam int INTERP_MSB = 11;
  localparam int INTERP_LSB = 8;
  localparam int BIT_FIFO = 7;
  localparam int BIT_ALARM_OE = 4;
  localparam int BIT_ALARM_POL = 3;
  localparam int BIT_CLKDIV_SYNC = 2;
  localparam int BIT_SINC_P1 = 1;
  localparam int BIT_SINC_P2 = 0;
  localparam logic [3:0] INTERP_1X = 4'h0;
  localparam logic [3:0] INTERP_2X = 4'h1;
  localparam logic [3:0] INTERP_4X = 4'h2;
  localparam logic [3:0] INTERP_8X = 4'h4;
  localparam logic [3:0] INTERP_16X = 4'h8;
  localparam logic [2:0] DIV_STAGES = 3'h4;

  typedef struct packed {
    logic offset_corr_pair1_en;
    logic offset_corr_pair2_en;
    logic gain_phase_corr_pair1_en;
    logic gain_phase_corr_pair2_en;
    logic [3:0] interp_sel;
    logic [4:0] interp_factor;
    logic fifo_en;
    logic clkdiv_sync_en;
    logic sinc_comp_pair1_en;
    logic sinc_comp_pair2_en;
  } ctrl_s;

  typedef struct packed {
    logic [15:0] ctrl_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [3:0] div_phase_r;
    logic synced_r;
    logic sync_s1_r;
    logic sync_s2_r;
    logic sync_s3_r;
    logic alarm_s1_r;
    logic alarm_s2_r;
  } state_s;
endpackage

// File: hdl/datapath_control.sv
/*
  Datapath control word register: a Wishbone slave holding the 16-bit control
  word, decoded control outputs, alarm pin driver and divided-clock phase align.
  Assumes sync_i and alarm_i come from outside the clock domain.
*/
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module datapath_control (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  input wire logic sync_i,
  input wire logic alarm_i,
  output logic alarm_o,
  output logic alarm_oe_o,
  output dpctl_pkg::ctrl_s ctrl_o,
  output logic [3:0] div_phase_o
);
  dpctl_pkg::state_s s_r;
  dpctl_pkg::state_s s_nxt;
  logic req;
  logic hit_ctrl;
  logic hit_stat;
  logic sync_rise;
  logic [15:0] wmask;

  assign req = cyc_i & stb_i & ~s_r.ack_r;
  assign hit_ctrl = adr_i == dpctl_pkg::DATAPATH_CONTROL_0_OFS;
  assign hit_stat = adr_i == dpctl_pkg::CTRL_STATUS_OFS;
  // edge taken between settled flops only; the first flop may still be metastable
  assign sync_rise = s_r.sync_s2_r & ~s_r.sync_s3_r;
  assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}} & ~dpctl_pkg::RESERVED_MASK;

  always_comb begin
    s_nxt = s_r;
    s_nxt.sync_s1_r = sync_i;
    s_nxt.sync_s2_r = s_r.sync_s1_r;
    s_nxt.sync_s3_r = s_r.sync_s2_r;
    s_nxt.alarm_s1_r = alarm_i;
    s_nxt.alarm_s2_r = s_r.alarm_s1_r;
    s_nxt.ack_r = req & (hit_ctrl | hit_stat);
    if (req && hit_ctrl && we_i) begin
      // reserved bits never written, so they stay zero
      s_nxt.ctrl_r = (s_r.ctrl_r & ~wmask) | (dat_i[15:0] & wmask);
    end
    if (req && hit_ctrl) begin
      s_nxt.dat_r = {16'h0000, s_r.ctrl_r};
    end else if (req && hit_stat) begin
      s_nxt.dat_r = {26'h0000000, s_r.synced_r, s_r.alarm_s2_r, s_r.div_phase_r};
    end else begin
      s_nxt.dat_r = 32'h00000000;
    end
    // free-running divider phase; with bit 2 set, a sync edge realigns all divided clocks
    if (s_r.ctrl_r[dpctl_pkg::BIT_CLKDIV_SYNC] && sync_rise) begin
      s_nxt.div_phase_r = 4'h0;
      s_nxt.synced_r = 1'b1;
    end else begin
      s_nxt.div_phase_r = s_r.div_phase_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.ctrl_r <= dpctl_pkg::DATAPATH_CONTROL_0_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    ctrl_o.offset_corr_pair1_en = s_r.ctrl_r[dpctl_pkg::BIT_OFFSET_P1];
    ctrl_o.offset_corr_pair2_en = s_r.ctrl_r[dpctl_pkg::BIT_OFFSET_P2];
    ctrl_o.gain_phase_corr_pair1_en = s_r.ctrl_r[dpctl_pkg::BIT_GP_P1];
    ctrl_o.gain_phase_corr_pair2_en = s_r.ctrl_r[dpctl_pkg::BIT_GP_P2];
    ctrl_o.interp_sel = s_r.ctrl_r[dpctl_pkg::INTERP_MSB:dpctl_pkg::INTERP_LSB];
    // factor as one-hot 1x..16x; undefined codes give all zero
    case (ctrl_o.interp_sel)
      dpctl_pkg::INTERP_1X: ctrl_o.interp_factor = 5'h01;
      dpctl_pkg::INTERP_2X: ctrl_o.interp_factor = 5'h02;
      dpctl_pkg::INTERP_4X: ctrl_o.interp_factor = 5'h04;
      dpctl_pkg::INTERP_8X: ctrl_o.interp_factor = 5'h08;
      dpctl_pkg::INTERP_16X: ctrl_o.interp_factor = 5'h10;
      default: ctrl_o.interp_factor = 5'h00;
    endcase
    ctrl_o.fifo_en = s_r.ctrl_r[dpctl_pkg::BIT_FIFO];
    ctrl_o.clkdiv_sync_en = s_r.ctrl_r[dpctl_pkg::BIT_CLKDIV_SYNC];
    ctrl_o.sinc_comp_pair1_en = s_r.ctrl_r[dpctl_pkg::BIT_SINC_P1];
    ctrl_o.sinc_comp_pair2_en = s_r.ctrl_r[dpctl_pkg::BIT_SINC_P2];
  end

  assign alarm_oe_o = s_r.ctrl_r[dpctl_pkg::BIT_ALARM_OE];
  // negative logic inverts the internal active-high alarm
  assign alarm_o = ~(s_r.alarm_s2_r ^ s_r.ctrl_r[dpctl_pkg::BIT_ALARM_POL]);
  assign div_phase_o = s_r.div_phase_r;
  assign dat_o = s_r.dat_r;
  assign ack_o = s_r.ack_r;
  assign err_o = 1'b0;
endmodule // datapath_control

// File: sim/dpctl_properties.sv
/* assertions for the control word register block
   assumes a bind onto datapath_control, one clock */
`timescale 1ns/1ps
module dpctl_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire dpctl_pkg::ctrl_s ctrl_o,
  input wire logic [3:0] div_phase_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr;
  assign wr = cyc_i && stb_i && we_i && !ack_o && adr_i == dpctl_pkg::DATAPATH_CONTROL_0_OFS;
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_ack_reply: assert property (cyc_i && stb_i && !ack_o && adr_i == 8'h00 |=> ack_o)
    else $error("no ack");
  a_ctrl_hold: assert property (!wr |=> $stable(ctrl_o)) else $error("ctrl moved");
  a_high_bits: assert property (
    wr && sel_i[1] |=> ctrl_o[16:13] == $past(dat_i[15:12])) else $error("bad high bits");
  a_interp_sel: assert property (
    wr && sel_i[1] |=> ctrl_o.interp_sel == $past(dat_i[11:8])) else $error("bad interp");
  a_interp_map: assert property (
    ctrl_o.interp_sel == 4'h8 |-> ctrl_o.interp_factor == 5'h10) else $error("bad 16x");
  a_low_bits: assert property (wr && sel_i[0] |=>
    {ctrl_o[3:0]} == $past({dat_i[7], dat_i[2:0]})) else $error("bad low bits");
  a_rsvd_zero: assert property (ack_o && !we_i && adr_i == 8'h00 |->
    {dat_o[31:16], dat_o[6:5]} == 18'h00000) else $error("reserved bits set");
  a_phase_step: assert property (
    div_phase_o == 4'h0 || div_phase_o == $past(div_phase_o) + 4'h1) else $error("phase jump");
endmodule // dpctl_properties
bind datapath_control dpctl_properties u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .ctrl_o, .div_phase_o);

// File: sim/test_dac_datapath_control_word.sv
/* bench for the control word register block
   assumes single-cycle classic bus answers */
`timescale 1ns/1ps
module test_dac_datapath_control_word;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sync_i = 0, alarm_i = 0;
  logic [7:0] adr_i = 0;
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, q;
  logic ack_o, err_o, alarm_o, alarm_oe_o;
  dpctl_pkg::ctrl_s ctrl_o;
  logic [3:0] codes[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
  logic [4:0] facs[6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00};
  int fail_count = 0, n_tests = 0, ncyc = 0;
  always #5 clk_i = ~clk_i;
  datapath_control DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .err_o, .sync_i, .alarm_i, .alarm_o, .alarm_oe_o, .ctrl_o,
    .div_phase_o());
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    ncyc <= ncyc + 1;
    if (ncyc == 2000) begin
      fail_count++;
      test_done;
    end
  end
  // request held until ack is seen at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, s};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic pulse_sync;
    sync_i <= 1;
    repeat (4) @(posedge clk_i);
    sync_i <= 0;
    repeat (4) @(posedge clk_i);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    bus(0, 8'h00, 0, 0);
    chk(q, 32'h0000049C);
    chk(ctrl_o, 32'h088C);
    chk(alarm_oe_o, 1);
    foreach (codes[i]) begin
      bus(1, 8'h00, {codes[i], 8'h00}, 4'h2);
      chk(ctrl_o.interp_factor, facs[i]);
    end
    bus(1, 8'h00, 32'hFFFF, 4'h3);
    chk(ctrl_o[16:13], 4'hF);
    chk(ctrl_o, 32'h1FE0F);
    bus(0, 8'h00, 0, 0);
    chk(q, 32'h0000FF9F);
    bus(1, 8'h00, 0, 4'h1);
    bus(0, 8'h00, 0, 0);
    chk(q, 32'h0000FF00);
    alarm_i <= 1;
    bus(1, 8'h00, 32'h18, 4'h1);
    repeat (3) @(posedge clk_i);
    chk(alarm_o, 1);
    bus(1, 8'h00, 32'h10, 4'h1);
    repeat (3) @(posedge clk_i);
    chk(alarm_o, 0);
    // negative logic with the alarm idle must drive the pin high
    alarm_i <= 0;
    repeat (3) @(posedge clk_i);
    chk(alarm_o, 1);
    bus(1, 8'h00, 0, 4'h1);
    chk(alarm_oe_o, 0);
    pulse_sync;
    bus(0, 8'h04, 0, 0);
    chk(q[5], 0);
    bus(1, 8'h00, 32'h04, 4'h1);
    pulse_sync;
    bus(0, 8'h04, 0, 0);
    chk(q[5], 1);
    // two synchroniser flops plus the edge flop, then five cycles of counting
    chk(q[3:0], 4'h5);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    bus(0, 8'h00, 0, 0);
    chk(q, 32'h0000049C);
    chk(alarm_oe_o, 1);
    {cyc_i, stb_i, we_i, adr_i} <= {3'h6, 8'h40};
    repeat (3) @(posedge clk_i);
    chk(ack_o, 0);
    chk(err_o, 0);
    test_done;
  end
endmodule // test_dac_datapath_control_word
